// ===== verilog/inertia_ratio_switching.sv
// Inertia ratio switching: parameter registers on APB and ratio selection for the control loop
// Function
// - Select input off applies first ratio, on applies second ratio.
// - Expansion bit 1 set enables switching; cleared makes switching invalid.
// - Expansion bit 2 set limits second ratio to first gain set active.
// - Switching works in every control mode code 0 through 6.
// - Switching only active while the drive is servo-on.
// - Both ratios mean load inertia over rotor inertia in the loop.
`default_nettype none
module inertia_ratio_switching
  import inertia_pkg::*;
#(
  parameter int RATIO_W = 16
)(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic               inertia_select,
  input  wire logic               servo_on,
  input  wire logic               first_gain_active,
  output logic      [RATIO_W-1:0] applied_inertia,
  output logic                    second_applied
);

  // ------------------------------------------------------------
  // Elaboration checks
  // ------------------------------------------------------------
  // A ratio wider than the stored reset value cannot be served
  if (RATIO_W < 1 || RATIO_W > 16)
  begin : g_bad_ratio_w
    $error("RATIO_W must be 1 to 16");
  end

  // ------------------------------------------------------------
  // Bus access decode
  // ------------------------------------------------------------
  logic               access;
  logic               first_access;
  logic               wr_en;
  logic               rd_en;

  assign access       = psel && penable;
  // Only the first access cycle acts; the cycle that shows pready must not repeat it
  assign first_access = access && !pready;
  assign wr_en        = first_access && pwrite;
  assign rd_en        = first_access && !pwrite;

  // ------------------------------------------------------------
  // Parameter registers
  // ------------------------------------------------------------
  logic [3:0]         control_mode_param_q, control_mode_param_d;
  logic [3:0]         autotune_mode_param_q, autotune_mode_param_d;
  logic [3:0]         adaptive_filter_param_q, adaptive_filter_param_d;
  logic [15:0]        function_expansion_param_q, function_expansion_param_d;
  logic [15:0]        disturbance_observer_param_q, disturbance_observer_param_d;
  logic [RATIO_W-1:0] first_inertia_param_q, first_inertia_param_d;
  logic [RATIO_W-1:0] second_inertia_param_q, second_inertia_param_d;
  logic [3:0]         status_vec;
  logic [31:0]        read_word;
  logic               mapped;
  logic               refused;

  // Read multiplexer; narrow fields sit in the low bits and the rest reads as zero
  always_comb
  begin
    read_word = 32'h0000_0000;
    mapped    = 1'b1;
    case (paddr)
      OFS_CONTROL_MODE:   read_word = {28'h0, control_mode_param_q};
      OFS_AUTOTUNE_MODE:  read_word = {28'h0, autotune_mode_param_q};
      OFS_ADAPT_FILTER:   read_word = {28'h0, adaptive_filter_param_q};
      OFS_FUNC_EXPAND:    read_word = {16'h0, function_expansion_param_q};
      OFS_DIST_OBS:       read_word = {16'h0, disturbance_observer_param_q};
      OFS_FIRST_INERTIA:  read_word = 32'(first_inertia_param_q);
      OFS_SECOND_INERTIA: read_word = 32'(second_inertia_param_q);
      OFS_STATUS:         read_word = {28'h0, status_vec};
      default:            mapped    = 1'b0;
    endcase
    // Modes above 6 do not exist; the write is refused with an error
    refused = !mapped || (pwrite && paddr == OFS_STATUS) ||
              (pwrite && paddr == OFS_CONTROL_MODE && pwdata[3:0] > CONTROL_MODE_MAX);
  end

  // Refused writes leave every register as it was
  always_comb
  begin
    control_mode_param_d         = control_mode_param_q;
    autotune_mode_param_d        = autotune_mode_param_q;
    adaptive_filter_param_d      = adaptive_filter_param_q;
    function_expansion_param_d   = function_expansion_param_q;
    disturbance_observer_param_d = disturbance_observer_param_q;
    first_inertia_param_d        = first_inertia_param_q;
    second_inertia_param_d       = second_inertia_param_q;
    if (wr_en && !refused)
    begin
      case (paddr)
        OFS_CONTROL_MODE:   control_mode_param_d = pwdata[3:0];
        OFS_AUTOTUNE_MODE:  autotune_mode_param_d = pwdata[3:0];
        OFS_ADAPT_FILTER:   adaptive_filter_param_d = pwdata[3:0];
        OFS_FUNC_EXPAND:    function_expansion_param_d = pwdata[15:0];
        OFS_DIST_OBS:       disturbance_observer_param_d = pwdata[15:0];
        OFS_FIRST_INERTIA:  first_inertia_param_d = pwdata[RATIO_W-1:0];
        OFS_SECOND_INERTIA: second_inertia_param_d = pwdata[RATIO_W-1:0];
        default:            ;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      control_mode_param_q         <= RST_CONTROL_MODE;
      autotune_mode_param_q        <= RST_AUTOTUNE;
      adaptive_filter_param_q      <= RST_ADAPT;
      function_expansion_param_q   <= RST_FUNC_EXPAND;
      disturbance_observer_param_q <= RST_DIST_OBS;
      first_inertia_param_q        <= RATIO_W'(RST_INERTIA);
      second_inertia_param_q       <= RATIO_W'(RST_INERTIA);
    end
    else
    begin
      control_mode_param_q         <= control_mode_param_d;
      autotune_mode_param_q        <= autotune_mode_param_d;
      adaptive_filter_param_q      <= adaptive_filter_param_d;
      function_expansion_param_q   <= function_expansion_param_d;
      disturbance_observer_param_q <= disturbance_observer_param_d;
      first_inertia_param_q        <= first_inertia_param_d;
      second_inertia_param_q       <= second_inertia_param_d;
    end
  end

  // ------------------------------------------------------------
  // Bus response
  // ------------------------------------------------------------
  logic [31:0]        prdata_d;
  logic               pready_d;
  logic               pslverr_d;

  // One wait state: the answer is a registered copy of the first access cycle
  always_comb
  begin
    pready_d  = first_access;
    pslverr_d = first_access && refused;
    // Read data holds between reads, so a late sample still sees the last answer
    prdata_d  = rd_en ? read_word : prdata;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata  <= prdata_d;
      pready  <= pready_d;
      pslverr <= pslverr_d;
    end
  end

  // ------------------------------------------------------------
  // Ratio selection
  // ------------------------------------------------------------
  logic               mode_ok;
  logic               tuning_off;
  logic               observers_off;
  logic               switch_enabled;
  logic               gain_gate;
  logic               applicable;
  logic               use_second;
  logic [RATIO_W-1:0] applied_d;
  logic               second_applied_d;

  // Software-side preconditions are checked too, so a misconfigured drive falls back safely
  always_comb
  begin
    mode_ok          = control_mode_param_q <= CONTROL_MODE_MAX;
    tuning_off       = autotune_mode_param_q == 4'h0
                    && adaptive_filter_param_q == 4'h0;
    observers_off    = !function_expansion_param_q[FX_OBSERVER_BIT]
                    && !disturbance_observer_param_q[DOB_ENABLE_BIT];
    switch_enabled   = function_expansion_param_q[FX_ENABLE_BIT];
    // With the gain option set, the second ratio follows the first gain set
    gain_gate        = !function_expansion_param_q[FX_GAIN1_BIT] || first_gain_active;
    applicable       = servo_on && switch_enabled
                    && mode_ok && tuning_off && observers_off;
    // Select is used as given; stopping the motor before a change is the host's duty
    use_second       = applicable && gain_gate && inertia_select;
    applied_d        = use_second ? second_inertia_param_q : first_inertia_param_q;
    second_applied_d = use_second;
    status_vec                = 4'h0;
    status_vec[ST_SECOND_BIT] = second_applied;
    status_vec[ST_APPLIC_BIT] = applicable;
    status_vec[ST_SERVO_BIT]  = servo_on;
    status_vec[ST_SELECT_BIT] = inertia_select;
  end

  // ------------------------------------------------------------
  // Outputs to the control loop
  // ------------------------------------------------------------
  // Registered so the loop never sees a half-written parameter as a glitch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      applied_inertia <= RATIO_W'(RST_INERTIA);
      second_applied  <= 1'b0;
    end
    else
    begin
      applied_inertia <= applied_d;
      second_applied  <= second_applied_d;
    end
  end

endmodule // inertia_ratio_switching
`default_nettype wire

// ===== pkg/inertia_pkg.sv
// Package: register map, field positions and reset values of the inertia ratio switching block
`default_nettype none
package inertia_pkg;
  // ------------------------------------------------------------
  // Register byte offsets
  // ------------------------------------------------------------
  localparam logic [7:0] OFS_CONTROL_MODE  = 8'h00;
  localparam logic [7:0] OFS_AUTOTUNE_MODE = 8'h04;
  localparam logic [7:0] OFS_ADAPT_FILTER  = 8'h08;
  localparam logic [7:0] OFS_FUNC_EXPAND   = 8'h0C;
  localparam logic [7:0] OFS_DIST_OBS      = 8'h10;
  localparam logic [7:0] OFS_FIRST_INERTIA = 8'h14;
  localparam logic [7:0] OFS_SECOND_INERTIA = 8'h18;
  localparam logic [7:0] OFS_STATUS        = 8'h1C;
  // ------------------------------------------------------------
  // Field positions and limits
  // ------------------------------------------------------------
  localparam int FX_OBSERVER_BIT = 0;
  localparam int FX_ENABLE_BIT   = 1;
  localparam int FX_GAIN1_BIT    = 2;
  localparam int DOB_ENABLE_BIT  = 1;
  localparam logic [3:0] CONTROL_MODE_MAX = 4'h6;
  // Status bit positions
  localparam int ST_SECOND_BIT  = 0;
  localparam int ST_APPLIC_BIT  = 1;
  localparam int ST_SERVO_BIT   = 2;
  localparam int ST_SELECT_BIT  = 3;
  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic [3:0]  RST_CONTROL_MODE = 4'h0;
  localparam logic [3:0]  RST_AUTOTUNE     = 4'h0;
  localparam logic [3:0]  RST_ADAPT        = 4'h0;
  localparam logic [15:0] RST_FUNC_EXPAND  = 16'h0000;
  localparam logic [15:0] RST_DIST_OBS     = 16'h0000;
  localparam logic [15:0] RST_INERTIA      = 16'h0000;
endpackage
`default_nettype wire

// ===== sim/inertia_props.sv
// Checker: port-level properties of the inertia ratio switching block
`default_nettype none
module inertia_props
  import inertia_pkg::*;
(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        inertia_select,
  input wire logic        servo_on,
  input wire logic        second_applied
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_sel_off_first: assert property (!inertia_select |=> !second_applied)
    else $error("second ratio with select off");
  a_servo_off_first: assert property (!servo_on |=> !second_applied)
    else $error("second ratio while servo off");
  a_ready_wait: assert property (psel && penable && !pready |=> pready) else $error("no ready");
  a_ready_pulse: assert property (pready |=> !pready) else $error("ready too long");
  a_ready_idle: assert property (!(psel && penable) |=> !pready) else $error("stray ready");
  a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
  a_data_hold: assert property (!psel |=> $stable(prdata)) else $error("read data moved");
  a_status_refused: assert property (psel && penable && !pready && pwrite
    && paddr == OFS_STATUS |=> pslverr) else $error("status write accepted");
endmodule // inertia_props
bind inertia_ratio_switching inertia_props u_props (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .inertia_select(inertia_select),
  .servo_on(servo_on), .second_applied(second_applied));
`default_nettype wire

// ===== sim/host_model.sv
// Host controller model driving the inertia select input
`default_nettype none
module host_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic want_second,
  input  wire logic motor_stopped,
  output wire logic inertia_select
);
  logic sel_q;
  logic sel_d;
  // A request made while moving waits for standstill, avoiding oscillation
  always_comb sel_d = motor_stopped ? want_second : sel_q;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn) sel_q <= 1'b0;
    else sel_q <= sel_d;
  assign inertia_select = sel_q;
endmodule // host_model
`default_nettype wire

// ===== sim/testbench.sv
// Testbench: APB accesses and randomised ratio selection checks
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("FAIL t=%0t got %h exp %h", $time, g, e); end end
module testbench
  import inertia_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic        servo_on = 0, gain_on = 0, want = 0, stopped = 1;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdata;
  logic        pready, pslverr, serr, sel, second, e, app;
  logic [15:0] applied, r1, r2, fx, dob;
  logic [3:0]  mode, at, af, exp_st;
  integer      err_count = 0, n_compared = 0, seed = 32'h7e35, n;
  always #2.5 pclk = ~pclk;
  inertia_ratio_switching #(.RATIO_W(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .inertia_select(sel), .servo_on(servo_on),
    .first_gain_active(gain_on), .applied_inertia(applied), .second_applied(second));
  host_model host (.pclk(pclk), .presetn(presetn), .want_second(want),
    .motor_stopped(stopped), .inertia_select(sel));
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rdata = prdata;
    serr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  // Preconditions under which the second ratio may be chosen at all
  function automatic logic switch_ok(input logic s_on, input logic [3:0] m, t, f,
                                     input logic [15:0] x, d);
    return s_on && m <= CONTROL_MODE_MAX && t == 4'h0 && f == 4'h0
      && x[1] && !x[0] && !d[1];
  endfunction
  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 9; i++)
    begin
      apb(1'b0, 8'(i * 4), 32'h0);
      `CHK(serr, i == 8)
      `CHK(rdata, 32'h0)
    end
    apb(1'b1, OFS_STATUS, 32'hF);
    `CHK(serr, 1'b1)
    apb(1'b1, OFS_CONTROL_MODE, 32'h7);
    `CHK(serr, 1'b1)
    r1 = 16'($random(seed));
    r2 = 16'($random(seed));
    apb(1'b1, OFS_FIRST_INERTIA, {16'h0, r1});
    apb(1'b1, OFS_SECOND_INERTIA, {16'h0, r2});
    for (int i = 0; i < 70; i++)
    begin
      n = $random(seed);
      mode = 4'(i % 7);
      at = {3'h0, n[3:0] == 4'h0};
      af = {3'h0, n[7:4] == 4'h0};
      fx = {13'h0, n[12], n[10] | n[11], n[9:8] == 2'h0};
      dob = {14'h0, n[14:13] == 2'h0, 1'b0};
      servo_on <= n[15] | n[16];
      gain_on  <= n[17];
      want     <= n[18];
      stopped  <= n[19] | n[20];
      apb(1'b1, OFS_CONTROL_MODE, {28'h0, mode});
      `CHK(serr, 1'b0)
      apb(1'b1, OFS_AUTOTUNE_MODE, {28'h0, at});
      apb(1'b1, OFS_ADAPT_FILTER, {28'h0, af});
      apb(1'b1, OFS_FUNC_EXPAND, {16'h0, fx});
      apb(1'b1, OFS_DIST_OBS, {16'h0, dob});
      repeat (2) @(posedge pclk);
      app = switch_ok(servo_on, mode, at, af, fx, dob);
      e = app && sel && (!fx[2] || gain_on);
      `CHK(second, e)
      `CHK(applied, e ? r2 : r1)
      apb(1'b0, OFS_STATUS, 32'h0);
      exp_st = {sel, servo_on, app, e};
      `CHK(rdata[3:0], exp_st)
    end
    // Mid-run reset: both loop outputs and the second ratio register return to zero
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    `CHK(applied, 16'h0000)
    `CHK(second, 1'b0)
    apb(1'b0, OFS_SECOND_INERTIA, 32'h0);
    `CHK(rdata, 32'h0)
    complete_run();
  end
  initial
  begin
    #200000;
    err_count++;
    complete_run();
  end
endmodule // testbench
`default_nettype wire
